// file: dpds_pkg.sv
package dpds_pkg;

   // ------------------------------------------------------------
   // timing: ns figures and derived cycle counts at 125 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 8000;
   localparam int IN_DIS_NS          = 16;
   localparam int OUT_FLOAT_NS       = 16;
   localparam int FIXED_OUT_NS       = 40;
   localparam int ACT_NS             = 80;
   localparam int STAB_NS            = 400;
   localparam int IN_DIS_CYC    = (IN_DIS_NS * 1000) / CLK_PERIOD_PS;
   localparam int OUT_FLOAT_CYC = (OUT_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int FIXED_OUT_CYC = (FIXED_OUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int ACT_CYC       = (ACT_NS * 1000) / CLK_PERIOD_PS;
   localparam int STAB_CYC      = (STAB_NS * 1000 + CLK_PERIOD_PS - 1)
                                  / CLK_PERIOD_PS;
   localparam int CNT_W              = 16;
   localparam int PAR_HOLD_CYC       = 1;

   // ------------------------------------------------------------
   // fixed levels and modes
   // ------------------------------------------------------------
   localparam logic [15:0] FIXED_ADDR = 16'h0000;
   localparam logic        TERM_ON    = 1'h0;
   localparam logic        TERM_OFF   = 1'h1;

   typedef enum logic [2:0] {
      DPDS_RUN, DPDS_ENTER, DPDS_PD, DPDS_FIXED, DPDS_STOPPED, DPDS_WAKE
   } dpds_state_e;

   typedef struct packed {
      logic        row_strobe;
      logic        column_strobe;
      logic        write_enable;
      logic [15:0] address;
   } dpds_cmd_s;

endpackage

// file: dpds_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - with power-down enabled, both cke low after a fall enters power-down
// - reset floats outputs and drives all four cke outputs low
// - termination off: only clock, cke, feedback and reset receivers live
// - input buffers off within input_disable_delay after both cke latched low
// - parity receiver stays on one clock longer than command receivers
// - power-down disables outputs except clocks, odt and cke
// - termination off: odt and cke outputs driven low
// - other outputs float output_float_delay cycles after cke outputs low
// - termination on: termination and odt receivers stay on; host drives odt
// - cke rise: matching cke out high, chip selects high, odt low if off
// - termination on: odt outputs follow inputs on exit
// - exit holds command outputs fixed for fixed_output_time, then follow
// - chip-select outputs held high two clocks on exit (exit edge, then cs_hold)
// - clocks held low: stop, float all but cke outputs held low
// - outputs follow inputs within activation_time after clock resumes
module dpds_top
   import dpds_pkg::*;
#(
   parameter int IN_DIS     = IN_DIS_CYC,
   parameter int OUT_FLOAT  = OUT_FLOAT_CYC,
   parameter int FIXED_OUT  = FIXED_OUT_CYC,
   parameter int ACT        = ACT_CYC,
   parameter int STAB       = STAB_CYC
) (
   // clock, reset, enable
   input  wire logic                 CLK,
   input  wire logic                 RST_B,
   input  wire logic                 CE,
   // clock-stopped detect
   input  wire logic                 CLOCK_STOPPED,
   // control bits
   input  wire logic                 POWER_DOWN_ENABLE_BIT,
   input  wire logic                 TERMINATION_MODE_BIT,
   // host side
   input  wire logic [1:0]           CLOCK_ENABLE_IN,
   input  wire logic [1:0]           ODT_IN,
   input  wire logic [1:0]           CHIP_SELECT_IN_N,
   input  wire dpds_pkg::dpds_cmd_s  CMD_IN,
   // dram side
   output logic [3:0]                CLOCK_ENABLE_OUT,
   output logic [1:0]                ODT_OUT,
   output logic [1:0]                CHIP_SELECT_OUT_N,
   output dpds_pkg::dpds_cmd_s       CMD_OUT,
   output logic                      CMD_OUT_EN,
   output logic                      CLOCK_OUT_EN,
   // receiver controls
   output logic                      CMD_RX_EN,
   output logic                      PARITY_RX_EN,
   output logic                      ODT_RX_EN,
   output logic                      INPUT_TERMINATION_EN,
   output logic                      STANDBY
);
   import dpds_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) rst_sync <= 2'h0;
      else        rst_sync <= {rst_sync[0], 1'h1};
   end
   assign rst_n = rst_sync[1];

   // ------------------------------------------------------------
   // state and counters
   // ------------------------------------------------------------
   dpds_state_e        state, next_state;
   logic [CNT_W-1:0]   cnt, next_cnt;
   logic [1:0]         cke_q;
   logic               term_off;
   logic               cs_hold;
   logic               floated;
   logic               par_live;

   wire both_low   = (CLOCK_ENABLE_IN == 2'h0);
   wire any_fall   = |(cke_q & ~CLOCK_ENABLE_IN);
   wire any_rise   = |CLOCK_ENABLE_IN;
   wire enter_pd   = POWER_DOWN_ENABLE_BIT && both_low && any_fall;
   wire cnt_done   = (cnt == '0);

   always_comb begin
      next_state = state;
      next_cnt   = (cnt == '0) ? cnt : cnt - CNT_W'(1);
      case (state)
         DPDS_RUN: begin
            if (CLOCK_STOPPED) begin
               next_state = DPDS_STOPPED;
            end else if (enter_pd) begin
               next_state = DPDS_ENTER;
               next_cnt   = CNT_W'(IN_DIS - 1);
            end
         end
         DPDS_ENTER, DPDS_PD: begin
            if (CLOCK_STOPPED) begin
               next_state = DPDS_STOPPED;
            end else if (any_rise) begin
               next_state = DPDS_FIXED;
               next_cnt   = CNT_W'(FIXED_OUT);
            end else if (state == DPDS_ENTER && cnt_done) begin
               next_state = DPDS_PD;
               next_cnt   = CNT_W'(OUT_FLOAT);
            end
         end
         DPDS_FIXED: begin
            if (cnt_done) next_state = DPDS_RUN;
         end
         DPDS_STOPPED: begin
            if (!CLOCK_STOPPED) begin
               next_state = DPDS_WAKE;
               next_cnt   = CNT_W'(ACT - 1);
            end
         end
         DPDS_WAKE: begin
            if (CLOCK_STOPPED)  next_state = DPDS_STOPPED;
            else if (cnt_done)  next_state = DPDS_RUN;
         end
         default: next_state = DPDS_RUN;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= DPDS_RUN;
         cnt   <= '0;
      end else if (CE) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cke_q    <= 2'h3;
         term_off <= TERM_OFF;
         cs_hold  <= 1'h0;
         floated  <= 1'h0;
         par_live <= 1'h1;
      end else if (CE) begin
         cke_q    <= CLOCK_ENABLE_IN;
         if (state == DPDS_RUN && enter_pd)
            term_off <= TERMINATION_MODE_BIT;
         cs_hold  <= (state == DPDS_ENTER || state == DPDS_PD) && any_rise;
         floated  <= (state == DPDS_PD) && cnt_done;
         par_live <= !(state == DPDS_PD || state == DPDS_STOPPED);
      end
   end

   // ------------------------------------------------------------
   // output steering
   // ------------------------------------------------------------
   wire in_pd     = (state == DPDS_ENTER) || (state == DPDS_PD);
   wire stopped   = (state == DPDS_STOPPED) || (state == DPDS_WAKE);
   wire fixed_out = (state == DPDS_FIXED);
   wire exiting   = in_pd && any_rise;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CLOCK_ENABLE_OUT  <= 4'h0;
         ODT_OUT           <= 2'h0;
         CHIP_SELECT_OUT_N <= 2'h3;
         CMD_OUT           <= '0;
         CMD_OUT_EN        <= 1'h0;
      end else if (CE) begin
         CLOCK_ENABLE_OUT <= stopped ? 4'h0 : {2{CLOCK_ENABLE_IN}};
         if (stopped || ((in_pd || exiting || fixed_out) && term_off))
            ODT_OUT <= 2'h0;
         else
            ODT_OUT <= ODT_IN;
         if (exiting || cs_hold || stopped || in_pd)
            CHIP_SELECT_OUT_N <= 2'h3;
         else
            CHIP_SELECT_OUT_N <= CHIP_SELECT_IN_N;
         if (exiting || fixed_out) begin
            CMD_OUT <= '{1'h1, 1'h1, 1'h1, FIXED_ADDR};
         end else if (!in_pd && !stopped) begin
            CMD_OUT <= CMD_IN;
         end
         CMD_OUT_EN <= !(stopped || (floated && !exiting) ||
                         ((state == DPDS_PD) && cnt_done && !exiting));
      end
   end

   assign CLOCK_OUT_EN         = rst_n && !stopped;
   assign CMD_RX_EN            = rst_n && !(state == DPDS_PD || stopped);
   assign PARITY_RX_EN         = rst_n && par_live;
   assign ODT_RX_EN            = rst_n && !stopped && !(in_pd && term_off);
   assign INPUT_TERMINATION_EN = rst_n && !stopped && !(in_pd && term_off);
   assign STANDBY              = stopped;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_ENTRY: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && state == DPDS_RUN && !CLOCK_STOPPED && enter_pd
      |=> state == DPDS_ENTER) else $error("power-down entry missed");
   AST_STOP_CKE: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && state == DPDS_STOPPED |=> CLOCK_ENABLE_OUT == 4'h0 && !CMD_OUT_EN)
      else $error("stopped outputs wrong");
   AST_CKE_RISE: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && exiting |=> CLOCK_ENABLE_OUT[1:0] == $past(CLOCK_ENABLE_IN)
      && CHIP_SELECT_OUT_N == 2'h3) else $error("exit levels wrong");
   AST_ODT_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && in_pd && term_off |=> ODT_OUT == 2'h0) else $error("odt not low");
   AST_RX_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
      state == DPDS_PD |-> !CMD_RX_EN) else $error("receivers still on");
   AST_PAR: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && $rose(state == DPDS_PD) |-> PARITY_RX_EN) else $error("parity early off");
   AST_TERM_ON: assert property (@(posedge CLK) disable iff (!rst_n)
      in_pd && !term_off |-> ODT_RX_EN && INPUT_TERMINATION_EN)
      else $error("termination dropped");
   AST_FIXED: assert property (@(posedge CLK) disable iff (!rst_n)
      CE && fixed_out |=> CMD_OUT.address == FIXED_ADDR) else $error("not fixed");
   COV_PD: cover property (@(posedge CLK) state == DPDS_PD);
   COV_EXIT: cover property (@(posedge CLK) state == DPDS_FIXED);
   COV_STOP: cover property (@(posedge CLK) state == DPDS_WAKE);
   COV_TERM_ON: cover property (@(posedge CLK) state == DPDS_PD && !term_off);

   // ------------------------------------------------------------
   // wake-up age, for the activation bound
   // ------------------------------------------------------------
   logic [CNT_W-1:0] wake_age;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wake_age <= '0;
      end else if (CE) begin
         wake_age <= (state == DPDS_WAKE) ? wake_age + CNT_W'(1) : '0;
      end
   end

   // ------------------------------------------------------------
   // power-down checks
   // ------------------------------------------------------------
   AST_TERM_LATCH: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && state == DPDS_RUN && enter_pd
      |=> term_off == $past(TERMINATION_MODE_BIT))
      else $error("termination mode not latched");

   AST_IN_OFF: assert property (@(posedge CLK)
      disable iff (!rst_n)
      state == DPDS_PD && term_off
      |-> !CMD_RX_EN && !ODT_RX_EN && !INPUT_TERMINATION_EN)
      else $error("receivers on with termination off");

   AST_ENTER_LEN: assert property (@(posedge CLK)
      disable iff (!rst_n)
      state == DPDS_ENTER |-> cnt < CNT_W'(IN_DIS))
      else $error("input disable too slow");

   AST_PAR_OFF: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && state == DPDS_PD |=> !PARITY_RX_EN)
      else $error("parity receiver left on");

   AST_CLK_OUT: assert property (@(posedge CLK)
      disable iff (!rst_n)
      in_pd |-> CLOCK_OUT_EN)
      else $error("clock outputs stopped in power-down");

   AST_CMD_HOLD: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && in_pd && !any_rise |=> $stable(CMD_OUT))
      else $error("command taken in power-down");

   AST_FLOAT: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && state == DPDS_PD && cnt_done && !any_rise |=> !CMD_OUT_EN)
      else $error("command outputs not floated");

   AST_ODT_FOLLOW: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && in_pd && !term_off |=> ODT_OUT == $past(ODT_IN))
      else $error("odt not following with termination on");

   AST_FIXED_END: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && fixed_out && cnt_done |=> state == DPDS_RUN)
      else $error("fixed levels held too long");

   AST_CS_MAX: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && exiting ##1 CE ##1 CE
      |=> CHIP_SELECT_OUT_N == $past(CHIP_SELECT_IN_N))
      else $error("chip selects held high too long");

   // ------------------------------------------------------------
   // reset, stop, wake, cke mirror and clock-enable freeze checks
   // ------------------------------------------------------------
   AST_RST_LOW: assert property (@(posedge CLK)
      !rst_n |-> CLOCK_ENABLE_OUT == 4'h0 && !CMD_OUT_EN)
      else $error("outputs live in reset");

   AST_MIRROR: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CLOCK_ENABLE_OUT[3:2] == CLOCK_ENABLE_OUT[1:0])
      else $error("clock-enable copies differ");

   AST_STOP_OUT: assert property (@(posedge CLK)
      disable iff (!rst_n)
      CE && state == DPDS_STOPPED
      |=> CHIP_SELECT_OUT_N == 2'h3 && ODT_OUT == 2'h0 && !CLOCK_OUT_EN)
      else $error("outputs live while clocks stopped");

   AST_WAKE: assert property (@(posedge CLK)
      disable iff (!rst_n)
      state == DPDS_WAKE |-> wake_age < CNT_W'(ACT))
      else $error("wake-up too slow");

   AST_FREEZE: assert property (@(posedge CLK)
      disable iff (!rst_n)
      !CE |=> $stable(state) && $stable(cnt) && $stable(CMD_OUT))
      else $error("state moved with clock enable low");

endmodule // dpds_top

// file: dpds_host_model.sv
`timescale 1ns/1ps
module dpds_host_model
   import dpds_pkg::*;
(
   // stimulus
   input  wire logic          clk,
   input  wire logic [1:0]    op,
   input  wire logic [31:0]   rnd,
   // host bus
   output logic [1:0]         cke,
   output logic [1:0]         odt,
   output logic [1:0]         cs_n,
   output dpds_pkg::dpds_cmd_s cmd,
   output logic               stopped
);
   // ----------------------------------------
   // op: 0 run, 1 power-down, 2 exit, 3 clocks stopped
   // ----------------------------------------
   logic       flt = 1'b0;
   logic [1:0] hold = 2'h0;
   always @(negedge clk) flt <= ~flt;
   always @(posedge clk) begin
      if (op == 2'h0) begin
         hold <= rnd[3:2];
      end
   end
   assign cke = (op == 2'h0) ? 2'h3 : (op == 2'h2) ? 2'h1 : 2'h0;
   assign cs_n = (op == 2'h0) ? (rnd[0] ? 2'h2 : 2'h1) : 2'h3;
   assign odt = (op == 2'h0) ? rnd[3:2] : hold;
   // released command lines toggle every cycle
   assign cmd = op[0] ? {19{flt}} : rnd[22:4];
   assign stopped = (op == 2'h3);
endmodule // dpds_host_model

// file: tb_dimm_register_power_down_sequencer.sv
`timescale 1ns/1ps
module tb_dimm_register_power_down_sequencer;
   import dpds_pkg::*;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam int FO = 5, AC = 10, ST = 50;
   localparam logic [32:0] M_CKE = 33'h1E0000000, M_ODT = 33'h018000000,
      M_CS = 33'h006000000, M_EN = 33'h001000000, M_RX = 33'h000800000;
   localparam logic [32:0] M_PAR = 33'h000400000, M_ORX = 33'h000200000,
      M_TRM = 33'h000100000, M_SB = 33'h000080000, M_CMD = 33'h00007FFFF;
   logic        CLK = 1'b0;
   logic        RST_B = 1'b0;
   logic        pde = 1'b1;
   logic        tmb = TERM_OFF;
   logic        ce = 1'b1;
   logic        cko;
   logic [18:0] lc;
   logic [1:0]  op = 2'h1;
   logic [31:0] rnd = 32'h70A7;
   logic [1:0]  cke_i, odt_i, cs_i, odt_o, cs_o, h;
   logic [3:0]  cke_o;
   logic        stp, en, rx, par, orx, trm, sb;
   dpds_cmd_s   cmd_i, cmd_o;
   logic [32:0] qm[$], qv[$], m, v;
   int          fails = 0;
   int          cmp_count = 0;
   int          k;
   wire  [32:0] obs = {cke_o, odt_o, cs_o, en, rx, par, orx, trm, sb, cmd_o};
   always #4 CLK = ~CLK;
   dpds_host_model u_host (.clk(CLK), .op(op), .rnd(rnd), .cke(cke_i),
      .odt(odt_i), .cs_n(cs_i), .cmd(cmd_i), .stopped(stp));
   dpds_top #(.IN_DIS(2), .OUT_FLOAT(2), .FIXED_OUT(FO), .ACT(AC), .STAB(ST))
   u_dut (.CLK(CLK), .RST_B(RST_B), .CE(ce), .CLOCK_STOPPED(stp),
      .POWER_DOWN_ENABLE_BIT(pde), .TERMINATION_MODE_BIT(tmb),
      .CLOCK_ENABLE_IN(cke_i), .ODT_IN(odt_i), .CHIP_SELECT_IN_N(cs_i),
      .CMD_IN(cmd_i), .CLOCK_ENABLE_OUT(cke_o), .ODT_OUT(odt_o),
      .CHIP_SELECT_OUT_N(cs_o), .CMD_OUT(cmd_o), .CMD_OUT_EN(en),
      .CLOCK_OUT_EN(cko), .CMD_RX_EN(rx), .PARITY_RX_EN(par), .ODT_RX_EN(orx),
      .INPUT_TERMINATION_EN(trm), .STANDBY(sb));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic note(input logic [32:0] mk, input logic [32:0] vl);
      qm.push_back(mk);
      qv.push_back(vl);
   endtask
   task automatic go(input logic [1:0] o, input int n);
      repeat (n) begin
         @(negedge CLK);
         op = o;
         rnd = xs(rnd);
      end
   endtask
   task automatic follow(input int n);
      repeat (n) begin
         @(negedge CLK);
         note(M_CMD | M_CS, {6'h0, rnd[0] ? 2'h2 : 2'h1, 6'h0, rnd[22:4]});
         lc = rnd[22:4];
         rnd = xs(rnd);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // monitor: compares every queued note against settled outputs
   always @(negedge CLK) begin
      #1;
      while (qm.size() > 0) begin
         m = qm.pop_front();
         v = qv.pop_front();
         check(obs & m, v & m);
      end
   end
   initial begin
      repeat (3000) @(posedge CLK);
      fails++;
      give_verdict;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge CLK);
      note(M_CKE | M_ODT | M_EN, 33'h0);
      RST_B = 1'b1;
      go(2'h0, 6);
      follow(6);
      check(33'(cko), 33'h1);
      ce = 1'b0;
      go(2'h0, 3);
      note(M_CMD, {14'h0, lc});
      ce = 1'b1;
      pde = 1'b0;
      go(2'h1, 8);
      note(M_CKE | M_RX | M_EN, M_RX | M_EN);
      pde = 1'b1;
      go(2'h0, 4);
      go(2'h1, 1);
      k = 0;
      while (rx !== 1'b0 && k < 20) begin
         @(negedge CLK);
         k++;
      end
      check(33'(k <= 3), 33'h1);
      note(M_PAR | M_EN, M_PAR | M_EN);
      go(2'h1, 1);
      note(M_PAR, 33'h0);
      go(2'h1, 6);
      note(M_CKE | M_ODT | M_EN | M_ORX | M_TRM, 33'h0);
      go(2'h2, 1);
      @(negedge CLK);
      note(M_CKE | M_CS | M_ODT | M_EN | M_CMD, {4'h5, 4'h3, 1'b1, 5'h0, 3'h7, FIXED_ADDR});
      go(2'h2, FO - 2);
      note(M_CMD, {14'h0, 3'h7, FIXED_ADDR});
      go(2'h0, FO + 3);
      follow(4);
      tmb = TERM_ON;
      h = rnd[3:2];
      go(2'h1, 10);
      note(M_CKE | M_RX | M_ORX | M_TRM, M_ORX | M_TRM);
      go(2'h2, 1);
      @(negedge CLK);
      note(M_ODT | M_CKE, {4'h5, h, 27'h0});
      go(2'h0, FO + 3);
      go(2'h1, 10);
      go(2'h3, 8);
      note(M_CKE | M_EN | M_SB, M_SB);
      check(33'(cko), 33'h0);
      go(2'h1, AC + 3);
      note(M_CKE | M_CS | M_EN | M_SB, {8'h03, 1'b1, 24'h0});
      go(2'h1, ST - AC);
      go(2'h0, 4);
      follow(4);
      go(2'h1, 10);
      RST_B = 1'b0;
      go(2'h1, 2);
      note(M_CKE | M_ODT | M_EN | M_RX, 33'h0);
      go(2'h1, 2);
      give_verdict;
   end
endmodule // tb_dimm_register_power_down_sequencer
